// ===== rtl/psc_support_bits.sv
`timescale 1ns/1ps
// Overview of operation
// R1 - power-on request level reads at 02h bit6
// R2 - 12h bit1 software power-on, zero turns off
// R3 - power-on pin may bypass internal debounce path
// R4 - processor polls request, writes every controller
// R5 - ac sense state reads at 02h bit7
// R6 - 12h bit5 software controls ac_good_output function
// R7 - ac sense readable without reaching ac_good_output
// R8 - 13h bit2 software releases share clamp
// R9 - default clamp release at 75% or 88%
// R10 - 1bh bit1 drives fault pin directly
// R11 - 13h bit0 write clears fault latch
// R12 - processor clears latch when request not cycled
// R13 - monitor input five reads at 00h bit0
// R14 - smbus alert asserted on any fault
// R15 - write-only bits stored, read back zero
module psc_support_bits
    import psc_pkg::*;
#(
    parameter logic [6:0] SMB_ADDR = SMB_ADDR_DEFAULT
) (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_clk_en,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe,
    input wire logic i_power_request,
    input wire logic i_ac_sense,
    input wire logic i_monitor_input_five,
    input wire logic i_ramp_at_75,
    input wire logic i_ramp_at_88,
    input wire logic i_fault_event,
    input wire psc_cfg_t i_cfg,
    output logic o_power_on,
    output logic o_ac_good_output_function,
    output logic o_clamp_release,
    output logic o_fault_pin,
    output logic o_alert_out,
    output logic o_alert_oe
);

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [6:0] sync1;
    logic [6:0] sync2;
    logic scl_d;
    logic sda_d;

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            // bus pins idle high, the rest low so no function releases at reset
            sync1 <= 7'h60;
            sync2 <= 7'h60;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else if (i_clk_en) begin
            sync1 <= {i_scl, i_sda, i_power_request, i_ac_sense, i_monitor_input_five,
                      i_ramp_at_75, i_ramp_at_88};
            sync2 <= sync1;
            scl_d <= sync2[6];
            sda_d <= sync2[5];
        end
    end

    logic scl_s, sda_s, pwr_s, ac_s, monitor_input_five_s, r75_s, r88_s;
    assign {scl_s, sda_s, pwr_s, ac_s, monitor_input_five_s, r75_s, r88_s} = sync2;

    logic scl_rise, scl_fall, start_cond, stop_cond;
    assign scl_rise = scl_s & ~scl_d;
    assign scl_fall = ~scl_s & scl_d;
    assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
    assign stop_cond = scl_s & scl_d & ~sda_d & sda_s;

    // ************************************************************
    // read data
    // ************************************************************
    logic [7:0] ptr;
    logic [7:0] rd_byte;

    always_comb begin
        rd_byte = 8'h00; // R15
        if (ptr == REG_MONITOR_FLAGS) begin
            rd_byte[BIT_MONITOR_FIVE] = monitor_input_five_s; // R13
        end else if (ptr == REG_INPUT_STATE) begin
            rd_byte[BIT_POWER_REQ_RD] = pwr_s; // R1
            rd_byte[BIT_AC_SENSE_RD] = ac_s; // R5
        end
        // write-only and unmapped offsets read as zero
    end

    // ************************************************************
    // smbus slave
    // ************************************************************
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_ACK_A = 4'h3,
        ST_REG = 4'h2,
        ST_ACK_R = 4'h6,
        ST_WDATA = 4'h7,
        ST_ACK_W = 4'h5,
        ST_RDATA = 4'h4,
        ST_RACK = 4'hc
    } psc_state_t;

    psc_state_t state;
    logic [3:0] cnt;
    logic [7:0] shift;
    logic [7:0] tx;
    logic rw;
    logic nack;
    logic wr_pulse;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state <= ST_IDLE;
            cnt <= 4'h0;
            shift <= 8'h00;
            tx <= 8'h00;
            rw <= 1'b0;
            nack <= 1'b0;
            ptr <= 8'h00;
            o_sda_oe <= 1'b0;
            o_sda_out <= 1'b0;
            wr_pulse <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 8'h00;
        end else if (i_clk_en) begin
            wr_pulse <= 1'b0;
            if (stop_cond) begin
                state <= ST_IDLE;
                o_sda_oe <= 1'b0;
            end else if (start_cond) begin
                state <= ST_ADDR;
                cnt <= 4'h0;
                o_sda_oe <= 1'b0;
            end else if (scl_rise) begin
                if (state == ST_RACK) begin
                    nack <= sda_s;
                end else if (state == ST_ADDR || state == ST_REG || state == ST_WDATA
                             || state == ST_RDATA) begin
                    shift <= {shift[6:0], sda_s};
                    cnt <= cnt + 4'h1;
                end
            end else if (scl_fall) begin
                unique case (state)
                    ST_IDLE: begin
                    end
                    ST_ADDR: if (cnt == 4'h8) begin
                        if (shift[7:1] == SMB_ADDR) begin
                            state <= ST_ACK_A;
                            rw <= shift[0];
                            o_sda_oe <= 1'b1;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                    ST_ACK_A: begin
                        cnt <= 4'h0;
                        if (rw) begin
                            state <= ST_RDATA;
                            tx <= rd_byte;
                            o_sda_oe <= ~rd_byte[7];
                            ptr <= ptr + 8'h01;
                        end else begin
                            state <= ST_REG;
                            o_sda_oe <= 1'b0;
                        end
                    end
                    ST_REG: if (cnt == 4'h8) begin
                        state <= ST_ACK_R;
                        ptr <= shift;
                        o_sda_oe <= 1'b1;
                    end
                    ST_ACK_R, ST_ACK_W: begin
                        state <= ST_WDATA;
                        cnt <= 4'h0;
                        o_sda_oe <= 1'b0;
                    end
                    ST_WDATA: if (cnt == 4'h8) begin
                        state <= ST_ACK_W;
                        o_sda_oe <= 1'b1;
                        wr_pulse <= 1'b1;
                        wr_addr <= ptr;
                        wr_data <= shift;
                        ptr <= ptr + 8'h01;
                    end
                    ST_RDATA: begin
                        if (cnt == 4'h8) begin
                            state <= ST_RACK;
                            o_sda_oe <= 1'b0;
                        end else begin
                            tx <= {tx[6:0], 1'b0};
                            o_sda_oe <= ~tx[6];
                        end
                    end
                    ST_RACK: begin
                        if (nack) begin
                            state <= ST_IDLE;
                        end else begin
                            state <= ST_RDATA;
                            cnt <= 4'h0;
                            tx <= rd_byte;
                            o_sda_oe <= ~rd_byte[7];
                            ptr <= ptr + 8'h01;
                        end
                    end
                    default: begin
                        state <= ST_IDLE;
                        o_sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ************************************************************
    // write-only control storage
    // ************************************************************
    logic [7:0] ctrl_power_ac;
    logic [7:0] ctrl_clamp_latch;
    logic [7:0] ctrl_fault_drive;

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctrl_power_ac <= CTRL_RESET;
            ctrl_clamp_latch <= CTRL_RESET;
            ctrl_fault_drive <= CTRL_RESET;
        end else if (i_clk_en && wr_pulse) begin
            if (wr_addr == REG_SW_POWER_AC) begin
                ctrl_power_ac <= wr_data; // R15
            end
            if (wr_addr == REG_CLAMP_LATCH) begin
                ctrl_clamp_latch <= wr_data; // R15
            end
            if (wr_addr == REG_FAULT_DRIVE) begin
                ctrl_fault_drive <= wr_data; // R15
            end
        end
    end

    logic clr_pulse;
    assign clr_pulse = wr_pulse && wr_addr == REG_CLAMP_LATCH && wr_data[BIT_LATCH_CLEAR];

    // ************************************************************
    // controlled functions
    // ************************************************************
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_power_on <= 1'b0;
            o_ac_good_output_function <= 1'b0;
            o_clamp_release <= 1'b0;
        end else if (i_clk_en) begin
            if (i_cfg.sw_mode) begin
                o_power_on <= ctrl_power_ac[BIT_SW_POWER_ON]; // R2
                o_ac_good_output_function <= ctrl_power_ac[BIT_SW_AC_GOOD_OUTPUT]; // R6
            end else begin
                o_power_on <= i_cfg.power_pass & pwr_s; // R3
                o_ac_good_output_function <= i_cfg.ac_pass & ac_s; // R7
            end
            if (i_cfg.clamp_sw) begin
                o_clamp_release <= ctrl_clamp_latch[BIT_CLAMP_RELEASE]; // R8
            end else begin
                o_clamp_release <= i_cfg.clamp_at_88 ? r88_s : r75_s; // R9
            end
        end
    end

    // ************************************************************
    // fault latch, fault pin and alert
    // ************************************************************
    logic fault_latch;
    logic next_fault;

    // a new event wins over a clear in the same cycle
    assign next_fault = i_cfg.fault_latching ? ((fault_latch & ~clr_pulse) | i_fault_event)
                                             : i_fault_event; // R11

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            fault_latch <= 1'b0;
            o_fault_pin <= 1'b0;
            o_alert_oe <= 1'b0;
            o_alert_out <= 1'b0;
        end else if (i_clk_en) begin
            fault_latch <= next_fault;
            o_fault_pin <= next_fault | ctrl_fault_drive[BIT_FAULT_DRIVE]; // R10
            o_alert_oe <= next_fault; // R14
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);

    property p_rd_power_req;
        ptr == REG_INPUT_STATE |-> rd_byte[BIT_POWER_REQ_RD] == pwr_s;
    endproperty
    a_rd_power_req: assert property (p_rd_power_req) else $error("power request readback wrong"); // R1

    property p_rd_ac_sense;
        ptr == REG_INPUT_STATE |-> rd_byte[BIT_AC_SENSE_RD] == ac_s;
    endproperty
    a_rd_ac_sense: assert property (p_rd_ac_sense) else $error("ac sense readback wrong"); // R5

    property p_rd_monitor_input_five;
        ptr == REG_MONITOR_FLAGS |-> rd_byte == {7'h00, monitor_input_five_s};
    endproperty
    a_rd_monitor_input_five: assert property (p_rd_monitor_input_five) else $error("monitor five readback wrong"); // R13

    property p_wo_zero;
        (ptr == REG_SW_POWER_AC || ptr == REG_CLAMP_LATCH || ptr == REG_FAULT_DRIVE)
            |-> rd_byte == 8'h00;
    endproperty
    a_wo_zero: assert property (p_wo_zero) else $error("write-only register read nonzero"); // R15

    sequence s_wr_power_off;
        wr_pulse && wr_addr == REG_SW_POWER_AC && !wr_data[BIT_SW_POWER_ON]
            && i_cfg.sw_mode ##0 (i_clk_en && i_cfg.sw_mode)[*3];
    endsequence
    property p_power_off;
        s_wr_power_off |-> !o_power_on;
    endproperty
    a_power_off: assert property (p_power_off) else $error("power not off after zero write"); // R2

    sequence s_wr_ac_on;
        wr_pulse && wr_addr == REG_SW_POWER_AC && wr_data[BIT_SW_AC_GOOD_OUTPUT]
            && i_cfg.sw_mode ##0 (i_clk_en && i_cfg.sw_mode)[*3];
    endsequence
    property p_ac_on;
        s_wr_ac_on |-> o_ac_good_output_function;
    endproperty
    a_ac_on: assert property (p_ac_on) else $error("ac_good_output not set by write"); // R6

    property p_no_pass;
        i_clk_en && !i_cfg.sw_mode && !i_cfg.power_pass && !i_cfg.ac_pass
            |=> !o_power_on && !o_ac_good_output_function;
    endproperty
    a_no_pass: assert property (p_no_pass) else $error("pin level passed through"); // R3 R7

    property p_clamp_default;
        i_clk_en && !i_cfg.clamp_sw
            |=> o_clamp_release == ($past(i_cfg.clamp_at_88) ? $past(r88_s) : $past(r75_s));
    endproperty
    a_clamp_default: assert property (p_clamp_default) else $error("clamp release point wrong"); // R9

    property p_clamp_sw;
        i_clk_en && i_cfg.clamp_sw |=> o_clamp_release == $past(ctrl_clamp_latch[BIT_CLAMP_RELEASE]);
    endproperty
    a_clamp_sw: assert property (p_clamp_sw) else $error("clamp override ignored"); // R8

    property p_latch_clear;
        i_clk_en && clr_pulse && !i_fault_event ##1 i_clk_en |-> !fault_latch && !o_alert_oe;
    endproperty
    a_latch_clear: assert property (p_latch_clear) else $error("fault latch not cleared"); // R11

    property p_fault_drive;
        i_clk_en && ctrl_fault_drive[BIT_FAULT_DRIVE] |=> o_fault_pin;
    endproperty
    a_fault_drive: assert property (p_fault_drive) else $error("fault pin not driven"); // R10

    property p_alert;
        i_clk_en && i_fault_event |=> o_alert_oe && o_fault_pin;
    endproperty
    a_alert: assert property (p_alert) else $error("alert missing after fault"); // R14

endmodule // psc_support_bits

// ===== pkg/psc_pkg.sv
package psc_pkg;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [7:0] REG_MONITOR_FLAGS = 8'h00;
    localparam logic [7:0] REG_INPUT_STATE = 8'h02;
    localparam logic [7:0] REG_SW_POWER_AC = 8'h12;
    localparam logic [7:0] REG_CLAMP_LATCH = 8'h13;
    localparam logic [7:0] REG_FAULT_DRIVE = 8'h1b;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int BIT_MONITOR_FIVE = 0;
    localparam int BIT_POWER_REQ_RD = 6;
    localparam int BIT_AC_SENSE_RD = 7;
    localparam int BIT_SW_POWER_ON = 1;
    localparam int BIT_SW_AC_GOOD_OUTPUT = 5;
    localparam int BIT_LATCH_CLEAR = 0;
    localparam int BIT_CLAMP_RELEASE = 2;
    localparam int BIT_FAULT_DRIVE = 1;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [6:0] SMB_ADDR_DEFAULT = 7'h2c;

    // configuration straps from the surrounding logic
    typedef struct packed {
        logic sw_mode;
        logic power_pass;
        logic ac_pass;
        logic clamp_sw;
        logic clamp_at_88;
        logic fault_latching;
    } psc_cfg_t;

endpackage

// ===== tb/psc_smb_master.sv
`timescale 1ns/1ps
// ********************************************
// smbus microcontroller model
// ********************************************
module psc_smb_master
    import psc_pkg::*;
#(
    parameter logic [6:0] ADDR = SMB_ADDR_DEFAULT
) (
    input wire logic i_clk_sys,
    input wire logic i_sda_line,
    output logic o_scl,
    output logic o_sda_pull
);
    initial begin
        o_scl = 1'b1;
        o_sda_pull = 1'b0;
    end
    task automatic hp();
        repeat (8) @(posedge i_clk_sys);
    endtask
    // data moves only while scl is low
    task automatic bit_out(input logic b);
        hp();
        o_sda_pull <= ~b;
        hp();
        o_scl <= 1'b1;
        hp();
        o_scl <= 1'b0;
    endtask
    task automatic bit_in(output logic b);
        hp();
        o_sda_pull <= 1'b0;
        hp();
        o_scl <= 1'b1;
        hp();
        b = i_sda_line;
        o_scl <= 1'b0;
    endtask
    task automatic start();
        o_sda_pull <= 1'b0;
        hp();
        o_scl <= 1'b1;
        hp();
        o_sda_pull <= 1'b1;
        hp();
        o_scl <= 1'b0;
    endtask
    task automatic stop();
        hp();
        o_sda_pull <= 1'b1;
        hp();
        o_scl <= 1'b1;
        hp();
        o_sda_pull <= 1'b0;
        hp();
    endtask
    task automatic byte_out(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) bit_out(d[i]);
        bit_in(b);
        ack = ~b;
    endtask
    task automatic byte_in(input logic last, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) bit_in(d[i]);
        bit_out(last);
    endtask
    task automatic wr_reg(input logic [7:0] p, input logic [7:0] d, output logic ok);
        logic a0, a1, a2;
        start();
        byte_out({ADDR, 1'b0}, a0);
        byte_out(p, a1);
        byte_out(d, a2);
        stop();
        ok = a0 & a1 & a2;
    endtask
    task automatic rd_reg(input logic [7:0] p, output logic [7:0] d);
        logic a;
        start();
        byte_out({ADDR, 1'b0}, a);
        byte_out(p, a);
        start();
        byte_out({ADDR, 1'b1}, a);
        byte_in(1'b1, d);
        stop();
    endtask
    task automatic probe(input logic [6:0] adr, output logic ack);
        start();
        byte_out({adr, 1'b0}, ack);
        stop();
    endtask
    task automatic follow_request();
        logic [7:0] v;
        logic ok;
        rd_reg(REG_INPUT_STATE, v);
        wr_reg(REG_SW_POWER_AC, {6'h00, v[BIT_POWER_REQ_RD], 1'b0}, ok);
    endtask
    task automatic clear_latch();
        logic ok;
        wr_reg(REG_CLAMP_LATCH, 8'h01, ok);
    endtask
endmodule // psc_smb_master

// ===== tb/tb.sv
`timescale 1ns/1ps
// ********************************************
// support bits bench
// ********************************************
module tb
    import psc_pkg::*;
;
    logic clk, rst_n, scl, pull, sda_oe, preq, ac, monitor_input_five, r75, r88, fault;
    logic pwr, acok, clamp, fpin, alert_oe;
    logic clk_en, sda_out, alert_out;
    psc_cfg_t cfg;
    wire logic sda_line;
    int miscompares, comparisons, cycles;
    assign sda_line = ~(sda_oe | pull);
    psc_support_bits #(.SMB_ADDR(SMB_ADDR_DEFAULT)) u_dut (
        .i_clk_sys(clk), .i_reset_n(rst_n), .i_clk_en(clk_en), .i_scl(scl),
        .i_sda(sda_line), .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_power_request(preq),
        .i_ac_sense(ac), .i_monitor_input_five(monitor_input_five), .i_ramp_at_75(r75),
        .i_ramp_at_88(r88), .i_fault_event(fault), .i_cfg(cfg), .o_power_on(pwr),
        .o_ac_good_output_function(acok), .o_clamp_release(clamp), .o_fault_pin(fpin),
        .o_alert_out(alert_out), .o_alert_oe(alert_oe));
    psc_smb_master #(.ADDR(SMB_ADDR_DEFAULT)) u_mst (
        .i_clk_sys(clk), .i_sda_line(sda_line), .o_scl(scl), .o_sda_pull(pull));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic close_out();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            miscompares++;
            close_out();
        end
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        logic ok;
        u_mst.wr_reg(p, d, ok);
        check("write ack", {7'h00, ok}, 8'h01);
        wt(3);
    endtask
    task automatic rd(input logic [7:0] p, input logic [7:0] exp, input string what);
        logic [7:0] v;
        u_mst.rd_reg(p, v);
        check(what, v, exp);
    endtask
    function automatic logic [7:0] b(input logic x);
        return {7'h00, x};
    endfunction
    task automatic t_readback();
        logic ack;
        preq <= 1'b1;
        monitor_input_five <= 1'b1;
        wt(5);
        rd(REG_INPUT_STATE, 8'h40, "input state");
        rd(REG_MONITOR_FLAGS, 8'h01, "monitor flags");
        preq <= 1'b0;
        ac <= 1'b1;
        monitor_input_five <= 1'b0;
        wt(5);
        rd(REG_INPUT_STATE, 8'h80, "input state");
        rd(REG_MONITOR_FLAGS, 8'h00, "monitor flags");
        rd(8'h05, 8'h00, "unmapped");
        u_mst.probe(SMB_ADDR_DEFAULT ^ 7'h01, ack);
        check("foreign ack", b(ack), 8'h00);
        check("sda out", b(sda_out), 8'h00);
        $display("test readback done");
    endtask
    task automatic t_sw_power();
        cfg.sw_mode <= 1'b1;
        wr(REG_SW_POWER_AC, 8'h02);
        check("power on", b(pwr), 8'h01);
        check("ac_good_output", b(acok), 8'h00);
        rd(REG_SW_POWER_AC, 8'h00, "control read");
        wr(REG_SW_POWER_AC, 8'h20);
        check("power on", b(pwr), 8'h00);
        check("ac_good_output", b(acok), 8'h01);
        wr(REG_SW_POWER_AC, 8'h00);
        check("ac_good_output", b(acok), 8'h00);
        preq <= 1'b1;
        wt(5);
        u_mst.follow_request();
        wt(3);
        check("power follow", b(pwr), 8'h01);
        $display("test software power done");
    endtask
    task automatic t_pass();
        cfg <= '0;
        wt(5);
        check("power blocked", b(pwr), 8'h00);
        check("ac blocked", b(acok), 8'h00);
        rd(REG_INPUT_STATE, 8'hc0, "input state");
        cfg <= '{power_pass: 1'b1, ac_pass: 1'b1, default: 1'b0};
        wt(5);
        check("power passed", b(pwr), 8'h01);
        check("ac passed", b(acok), 8'h01);
        // clock enable low freezes the pass-through path
        clk_en <= 1'b0;
        preq <= 1'b0;
        wt(5);
        check("power frozen", b(pwr), 8'h01);
        clk_en <= 1'b1;
        wt(5);
        check("power follows pin", b(pwr), 8'h00);
        $display("test pass-through done");
    endtask
    task automatic t_clamp();
        r75 <= 1'b1;
        wt(5);
        check("clamp 75", b(clamp), 8'h01);
        cfg.clamp_at_88 <= 1'b1;
        wt(5);
        check("clamp 88 low", b(clamp), 8'h00);
        r88 <= 1'b1;
        wt(5);
        check("clamp 88", b(clamp), 8'h01);
        cfg.clamp_sw <= 1'b1;
        wt(3);
        check("clamp sw off", b(clamp), 8'h00);
        wr(REG_CLAMP_LATCH, 8'h04);
        check("clamp sw on", b(clamp), 8'h01);
        rd(REG_CLAMP_LATCH, 8'h00, "clamp read");
        wr(REG_CLAMP_LATCH, 8'h00);
        check("clamp sw off", b(clamp), 8'h00);
        $display("test clamp done");
    endtask
    task automatic t_fault();
        cfg.fault_latching <= 1'b1;
        fault <= 1'b1;
        wt(1);
        fault <= 1'b0;
        wt(20);
        check("fault latched", b(fpin), 8'h01);
        check("alert", b(alert_oe), 8'h01);
        check("alert out", b(alert_out), 8'h00);
        u_mst.clear_latch();
        wt(3);
        check("fault cleared", b(fpin), 8'h00);
        check("alert cleared", b(alert_oe), 8'h00);
        wr(REG_FAULT_DRIVE, 8'h02);
        check("pin driven", b(fpin), 8'h01);
        check("no alert", b(alert_oe), 8'h00);
        rd(REG_FAULT_DRIVE, 8'h00, "drive read");
        wr(REG_FAULT_DRIVE, 8'h00);
        check("pin released", b(fpin), 8'h00);
        cfg.fault_latching <= 1'b0;
        fault <= 1'b1;
        wt(3);
        check("alert follow", b(alert_oe), 8'h01);
        fault <= 1'b0;
        wt(3);
        check("alert drop", b(alert_oe), 8'h00);
        $display("test fault done");
    endtask
    initial begin
        rst_n = 1'b0;
        cfg = '0;
        {preq, ac, monitor_input_five, r75, r88, fault} = '0;
        clk_en = 1'b1;
        wt(12);
        rst_n <= 1'b1;
        wt(5);
        t_readback();
        t_sw_power();
        t_pass();
        t_clamp();
        t_fault();
        close_out();
    end
endmodule // tb
